/* inc/ras_pkg.sv */
/*
 Package for the return-address stack: register location, widths, reset
 values, operation codes, the packed stack-slot type and the table-read phase codes.
 Assumes a single core clock and a sequencer that issues one op per cycle.
*/
// How it works
// - Index is a four-bit binary counter
// - Index readable and writable at location 01H
// - Index 0..14 selects entries; all-ones prohibited
// - Resets other than pin reset preset index to all ones; stop retains
// - Call decrements index, then stores return address
// - Return loads counter from entry, then increments
// - Table read loads buffer, restores counter, increments
// - Interrupt pushes like call; interrupt return pops
// - Pointer push decrements, stores pointer in entry
// - Pointer pop loads pointer, then increments index
// - System call stores return address and segment
// - Return after system call restores both, increments
// - All-ones entry undefined; nesting at most fifteen
// - Optional reset on overflow or underflow detection
// - Fault reset enabled after power-on or pin reset
package ras_pkg;

  localparam int          IDX_W         = 4;       // Index width
  localparam int          ADDR_W        = 14;      // Program address width
  localparam int          SEG_W         = 2;       // Segment register width
  localparam int          PMEM_W        = 16;      // Program word width
  localparam int          DEPTH         = 15;      // Usable entries
  localparam logic [6:0]  IDX_REG_LOC   = 7'h01;   // Register-file location
  localparam logic [3:0]  IDX_RESET     = 4'hF;    // Preset value
  localparam logic [3:0]  IDX_BOTTOM    = 4'h0;    // Deepest usable entry
  localparam logic        FAULT_EN_RST  = 1'b1;    // Fault reset on at power-on

  // Stack operation codes, one-hot except OP_NONE, which is all zeros
  typedef enum logic [8:0] {
    OP_NONE      = 9'h000,
    OP_CALL      = 9'h001,
    OP_RET       = 9'h002,
    OP_RET_SKIP  = 9'h004,
    OP_IRQ       = 9'h008,
    OP_IRET      = 9'h010,
    OP_PUSH_PTR  = 9'h020,
    OP_POP_PTR   = 9'h040,
    OP_SYSCALL   = 9'h080,
    OP_TABLE     = 9'h100
  } stack_op_type;

  // One stack slot: return address plus saved segment
  typedef struct packed {
    logic [SEG_W-1:0]  seg;
    logic [ADDR_W-1:0] addr;
  } slot_type;

  // Table reference phase machine, one-hot
  typedef enum logic [1:0] {
    TBL_IDLE  = 2'b01,
    TBL_FETCH = 2'b10
  } tbl_state_type;

endpackage : ras_pkg

/* hw/return_address_stack.sv */
/*
 Return-address stack of a 4-bit core: index counter, fifteen slots,
 push/pop sequencing for calls, returns, interrupts, pointer moves,
 system calls and table reads, plus an optional fault reset request.
 Assumes the sequencer issues one op at a time and waits out table reads.
*/
module return_address_stack
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic               CLK_I,
  input  wire logic               SYS_RST_I,
  input  wire logic               POR_I,
  input  wire logic               PIN_RST_I,
  input  wire logic               WDT_RST_I,
  input  wire logic               CE_RST_I,
  // Sequencer commands
  input  wire stack_op_type       OP_I,
  input  wire logic [ADDR_W-1:0]  RET_ADDR_I,
  input  wire logic [SEG_W-1:0]   SEG_I,
  input  wire logic [ADDR_W-1:0]  PTR_I,
  // Register-file access
  input  wire logic               REG_WE_I,
  input  wire logic [6:0]         REG_ADDR_I,
  input  wire logic [IDX_W-1:0]   REG_WDATA_I,
  output logic      [IDX_W-1:0]   REG_RDATA_O,
  input  wire logic               FAULT_EN_WE_I,
  input  wire logic               FAULT_EN_I,
  // Program memory port for table reads
  output logic      [ADDR_W-1:0]  PMEM_ADDR_O,
  input  wire logic [PMEM_W-1:0]  PMEM_DATA_I,
  // Results to sequencer
  output logic                    PC_LOAD_O,
  output logic      [ADDR_W-1:0]  PC_O,
  output logic                    SEG_LOAD_O,
  output logic      [SEG_W-1:0]   SEG_O,
  output logic                    PTR_LOAD_O,
  output logic      [ADDR_W-1:0]  PTR_O,
  output logic                    DBUF_LOAD_O,
  output logic      [PMEM_W-1:0]  DBUF_O,
  output logic                    BUSY_O,
  // Fault reporting
  output logic                    OVERFLOW_O,
  output logic                    UNDERFLOW_O,
  output logic                    FAULT_RST_O,
  output logic                    FAULT_EN_O
);

  logic [IDX_W-1:0] return_stack_index_reg;          // Live index
  logic [IDX_W-1:0] return_stack_index_next;         // Index next value
  slot_type         return_address_slot [DEPTH];     // Fifteen slots
  tbl_state_type    tbl_state_reg;                   // Table read phase
  logic             fault_en_reg;                    // Fault reset enable
  logic             push_req;                        // Any push this cycle
  logic             pop_req;                         // Any pop this cycle
  logic             idx_wr;                          // Software index write
  logic             hard_rst;                        // Any index preset
  slot_type         top_slot;                        // Entry under index
  logic             ovf;                             // Push below entry 0
  logic             unf;                             // Pop past all-ones

  // Decrement and increment wrap as a plain counter would
  function automatic logic [IDX_W-1:0] step(input logic [IDX_W-1:0] v,
                                            input logic up);
    step = up ? IDX_W'(v + 1'b1) : IDX_W'(v - 1'b1);
  endfunction : step

  // Slot read; the all-ones entry has no storage and reads zero
  function automatic slot_type slot_at(input logic [IDX_W-1:0] i,
                                       input slot_type s [DEPTH]);
    slot_at = (i == IDX_RESET) ? '0 : s[i];
  endfunction : slot_at

  assign hard_rst = SYS_RST_I | POR_I | WDT_RST_I | CE_RST_I;
  assign idx_wr   = REG_WE_I && (REG_ADDR_I == IDX_REG_LOC);
  assign top_slot = slot_at(return_stack_index_reg, return_address_slot);

  // Push-type ops; table read pushes in its first phase
  assign push_req = (OP_I == OP_CALL) || (OP_I == OP_IRQ) ||
                    (OP_I == OP_PUSH_PTR) || (OP_I == OP_SYSCALL) ||
                    (OP_I == OP_TABLE && tbl_state_reg == TBL_IDLE);
  // Pop-type ops; table read pops in its fetch phase
  assign pop_req  = (OP_I == OP_RET) || (OP_I == OP_RET_SKIP) ||
                    (OP_I == OP_IRET) || (OP_I == OP_POP_PTR) ||
                    (tbl_state_reg == TBL_FETCH);

  // Fault detection: bottom push, or pop from the empty (all-ones) index
  assign ovf = push_req && (return_stack_index_reg == IDX_BOTTOM);
  assign unf = pop_req  && (return_stack_index_reg == IDX_RESET);

  // Next index: counter behaviour, software write loses to hardware ops
  always_comb begin
    return_stack_index_next = return_stack_index_reg;
    if (push_req) begin
      return_stack_index_next = step(return_stack_index_reg, 1'b0);
    end else if (pop_req) begin
      return_stack_index_next = step(return_stack_index_reg, 1'b1);
    end else if (idx_wr) begin
      // Writing all-ones is software's fault; stored as given
      return_stack_index_next = REG_WDATA_I;
    end
  end

  // Index counter; clock stop simply issues no op, so the value holds
  always_ff @(posedge CLK_I) begin
    if (hard_rst) begin
      return_stack_index_reg <= IDX_RESET;
    end else begin
      return_stack_index_reg <= return_stack_index_next;
    end
  end

  // Slot writes land in the entry selected after the decrement
  always_ff @(posedge CLK_I) begin
    if (push_req && !hard_rst &&
        return_stack_index_next != IDX_RESET) begin
      unique case (OP_I)
        OP_PUSH_PTR: begin
          return_address_slot[return_stack_index_next] <=
            '{seg: '0, addr: PTR_I};
        end
        OP_SYSCALL: begin
          return_address_slot[return_stack_index_next] <=
            '{seg: SEG_I, addr: RET_ADDR_I};
        end
        default: begin
          // Call, interrupt and table-read start keep segment as zero
          return_address_slot[return_stack_index_next] <=
            '{seg: '0, addr: RET_ADDR_I};
        end
      endcase
    end
  end

  // Table read sequencing: push phase then fetch-and-pop phase
  always_ff @(posedge CLK_I) begin
    if (hard_rst) begin
      tbl_state_reg <= TBL_IDLE;
    end else begin
      unique case (tbl_state_reg)
        TBL_IDLE: begin
          if (OP_I == OP_TABLE) begin
            tbl_state_reg <= TBL_FETCH;
          end
        end
        TBL_FETCH: begin
          tbl_state_reg <= TBL_IDLE;
        end
        default: begin
          tbl_state_reg <= TBL_IDLE;
        end
      endcase
    end
  end

  // Fault enable: on after power-on or pin reset, software may change
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || POR_I || PIN_RST_I) begin
      fault_en_reg <= FAULT_EN_RST;
    end else if (FAULT_EN_WE_I) begin
      fault_en_reg <= FAULT_EN_I;
    end
  end

  // Results registered so data outputs come from flip-flops
  always_ff @(posedge CLK_I) begin
    if (hard_rst) begin
      PC_LOAD_O   <= 1'b0;
      PC_O        <= '0;
      SEG_LOAD_O  <= 1'b0;
      SEG_O       <= '0;
      PTR_LOAD_O  <= 1'b0;
      PTR_O       <= '0;
      DBUF_LOAD_O <= 1'b0;
      DBUF_O      <= '0;
      OVERFLOW_O  <= 1'b0;
      UNDERFLOW_O <= 1'b0;
      FAULT_RST_O <= 1'b0;
    end else begin
      // Returns and table fetch reload counter from current entry
      PC_LOAD_O   <= (OP_I == OP_RET) || (OP_I == OP_RET_SKIP) ||
                     (OP_I == OP_IRET) ||
                     (tbl_state_reg == TBL_FETCH);
      PC_O        <= top_slot.addr;
      // Segment restore only meaningful after a system call
      SEG_LOAD_O  <= (OP_I == OP_RET) || (OP_I == OP_RET_SKIP);
      SEG_O       <= top_slot.seg;
      PTR_LOAD_O  <= (OP_I == OP_POP_PTR);
      PTR_O       <= top_slot.addr;
      DBUF_LOAD_O <= (tbl_state_reg == TBL_FETCH);
      DBUF_O      <= PMEM_DATA_I;
      OVERFLOW_O  <= ovf;
      UNDERFLOW_O <= unf;
      FAULT_RST_O <= fault_en_reg && (ovf || unf);
    end
  end

  // Pointer drives program memory address directly during a table read
  assign PMEM_ADDR_O = PTR_I;
  assign BUSY_O      = (tbl_state_reg == TBL_FETCH);
  assign REG_RDATA_O = return_stack_index_reg;
  assign FAULT_EN_O  = fault_en_reg;

  // Checks
  chk_reset_preset: assert property (@(posedge CLK_I)
    hard_rst |=> return_stack_index_reg == IDX_RESET)
    else $error("index not preset by reset");

  chk_push_decrement: assert property (@(posedge CLK_I)
    disable iff (hard_rst) (OP_I == OP_CALL && tbl_state_reg == TBL_IDLE)
    |=> return_stack_index_reg ==
        IDX_W'($past(return_stack_index_reg) - 1'b1))
    else $error("call did not decrement index");

  chk_call_return: assert property (@(posedge CLK_I)
    disable iff (SYS_RST_I || POR_I || WDT_RST_I || CE_RST_I)
    (OP_I == OP_CALL && tbl_state_reg == TBL_IDLE &&
     return_stack_index_reg != IDX_BOTTOM) ##1 (OP_I == OP_RET)
    |=> PC_LOAD_O && PC_O == $past(RET_ADDR_I, 2) &&
        return_stack_index_reg == $past(return_stack_index_reg, 2))
    else $error("return did not restore call address");

  chk_pop_ptr: assert property (@(posedge CLK_I)
    disable iff (hard_rst) (OP_I == OP_POP_PTR && tbl_state_reg == TBL_IDLE)
    |=> PTR_LOAD_O && return_stack_index_reg ==
        IDX_W'($past(return_stack_index_reg) + 1'b1))
    else $error("pointer pop wrong");

  chk_table_seq: assert property (@(posedge CLK_I)
    disable iff (hard_rst) (OP_I == OP_TABLE && tbl_state_reg == TBL_IDLE)
    |=> BUSY_O ##1 (DBUF_LOAD_O && PC_LOAD_O &&
        return_stack_index_reg == $past(return_stack_index_reg, 2)))
    else $error("table read sequence wrong");

  chk_fault_reset: assert property (@(posedge CLK_I)
    disable iff (hard_rst) (ovf || unf) && fault_en_reg |=> FAULT_RST_O)
    else $error("fault reset not raised");

  chk_fault_masked: assert property (@(posedge CLK_I)
    disable iff (hard_rst) !fault_en_reg |=> !FAULT_RST_O)
    else $error("fault reset while disabled");

  chk_enable_preset: assert property (@(posedge CLK_I)
    (POR_I || PIN_RST_I) |=> fault_en_reg)
    else $error("fault enable not preset");

  chk_idx_write: assert property (@(posedge CLK_I)
    disable iff (hard_rst) idx_wr && !push_req && !pop_req
    |=> return_stack_index_reg == $past(REG_WDATA_I))
    else $error("index write lost");

endmodule : return_address_stack

/* verification/prog_mem_model.sv */
/*
 Program memory model seen by table reads of the return-address stack.
 Assumes the stack drives the word address and samples the word itself.
*/
module prog_mem_model
  import ras_pkg::*;
(
  // Word address from the stack
  input  wire logic [ADDR_W-1:0] addr_i,
  // Program word back to the stack
  output logic      [PMEM_W-1:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Word differs per address, so a stale address shows up in the buffer
  always_comb begin
    data_o = {~addr_i[1:0], addr_i};
  end
endmodule : prog_mem_model

/* verification/tb_return_address_stack.sv */
/*
 Self-checking bench for the return-address stack.
 Assumes one 200 MHz clock; inputs change on the falling edge.
*/
module tb_return_address_stack
  import ras_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus, all given a value at time zero
  logic clk = 1'b0, rst = 1'b1, por = 1'b0, pin = 1'b0, wdt = 1'b0;
  logic ce = 1'b0, we = 1'b0, fen_we = 1'b0, fen = 1'b0;
  stack_op_type     op       = OP_NONE;
  logic [ADDR_W-1:0] ret_addr = 14'h0000;
  logic [ADDR_W-1:0] ptr      = 14'h0000;
  logic [SEG_W-1:0]  seg      = 2'h0;
  logic [6:0]        raddr    = 7'h00;
  logic [IDX_W-1:0]  wdata    = 4'h0;
  // Observed results
  logic [IDX_W-1:0]  rdata;
  logic [ADDR_W-1:0] pmem_addr, pc, ptr_o;
  logic [PMEM_W-1:0] pmem_data, dbuf;
  logic [SEG_W-1:0]  seg_o;
  logic pc_ld, seg_ld, ptr_ld, dbuf_ld, busy, ovf, udf, frst, fen_o;
  int                bad_count   = 0;  // Mismatches
  int                check_count = 0;  // Comparisons

  // 5 ns period
  always #2.5 clk = ~clk;

  return_address_stack i_return_address_stack (
    .CLK_I(clk), .SYS_RST_I(rst), .POR_I(por), .PIN_RST_I(pin),
    .WDT_RST_I(wdt), .CE_RST_I(ce), .OP_I(op), .RET_ADDR_I(ret_addr),
    .SEG_I(seg), .PTR_I(ptr), .REG_WE_I(we), .REG_ADDR_I(raddr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .FAULT_EN_WE_I(fen_we),
    .FAULT_EN_I(fen), .PMEM_ADDR_O(pmem_addr), .PMEM_DATA_I(pmem_data),
    .PC_LOAD_O(pc_ld), .PC_O(pc), .SEG_LOAD_O(seg_ld), .SEG_O(seg_o),
    .PTR_LOAD_O(ptr_ld), .PTR_O(ptr_o), .DBUF_LOAD_O(dbuf_ld),
    .DBUF_O(dbuf),
    .BUSY_O(busy), .OVERFLOW_O(ovf), .UNDERFLOW_O(udf),
    .FAULT_RST_O(frst), .FAULT_EN_O(fen_o));

  prog_mem_model i_prog_mem_model (.addr_i(pmem_addr), .data_o(pmem_data));

  // Single comparison point; unknowns never match
  task automatic check(input string what, input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // Op held over one rising edge; left up so ops run back to back
  task automatic run(input stack_op_type o, input logic [13:0] a);
    op = o;
    ret_addr = a;
    ptr = a;
    seg = a[1:0];
    @(negedge clk);
  endtask : run

  // Register-file write, strobe for one cycle
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    we = 1'b1;
    raddr = a;
    wdata = d;
    @(negedge clk);
    we = 1'b0;
    @(negedge clk);
  endtask : wr

  // Fifteen nested calls, then unwind with both return kinds
  task automatic t_nest;
    for (int i = 0; i < 15; i++) begin
      run(OP_CALL, 14'h1000 + 14'(i));
      check("index", 16'(14 - i), 16'(rdata));
    end
    for (int i = 14; i >= 0; i--) begin
      // First return follows the last call directly, a plain return
      run(i[0] ? OP_RET_SKIP : OP_RET, 14'h0000);
      check("pc", 16'h1000 + 16'(i), 16'(pc));
      check("pc load", 16'h0001, 16'(pc_ld));
      check("seg", 16'h0000, 16'(seg_o));
      check("index", 16'(15 - i), 16'(rdata));
    end
    run(OP_NONE, 14'h0000);
  endtask : t_nest

  // Interrupt, pointer and system-call pairs
  task automatic t_pairs;
    run(OP_IRQ, 14'h02AB);
    run(OP_IRET, 14'h0000);
    check("pc", 16'h02AB, 16'(pc));
    run(OP_PUSH_PTR, 14'h03C5);
    check("index", 16'h000E, 16'(rdata));
    run(OP_POP_PTR, 14'h0000);
    check("ptr", 16'h03C5, 16'(ptr_o));
    check("ptr load", 16'h0001, 16'(ptr_ld));
    run(OP_SYSCALL, 14'h01E6);
    run(OP_RET, 14'h0000);
    check("pc", 16'h01E6, 16'(pc));
    check("seg", 16'h0002, 16'(seg_o));
    check("seg load", 16'h0001, 16'(seg_ld));
    run(OP_NONE, 14'h0000);
    check("index", 16'h000F, 16'(rdata));
  endtask : t_pairs

  // Table read: push, fetch cycle, then buffer and counter loads
  task automatic t_table;
    run(OP_TABLE, 14'h0A53);
    check("busy", 16'h0001, 16'(busy));
    check("index", 16'h000E, 16'(rdata));
    // Pointer moved off the return address, so the two cannot be confused
    run(OP_NONE, 14'h1234);
    check("data buffer", {2'h3, 14'h1234}, 16'(dbuf));
    check("data buffer load", 16'h0001, 16'(dbuf_ld));
    check("pc", 16'h0A53, 16'(pc));
    check("pc load", 16'h0001, 16'(pc_ld));
    check("index", 16'h000F, 16'(rdata));
  endtask : t_table

  // Index written directly; wrong location and idle cycles leave it
  task automatic t_reg;
    wr(7'h01, 4'h6);
    check("index", 16'h0006, 16'(rdata));
    wr(7'h02, 4'h3);
    repeat (4) @(negedge clk);
    check("index", 16'h0006, 16'(rdata));
    run(OP_CALL, 14'h0155);
    run(OP_NONE, 14'h0000);
    check("index", 16'h0005, 16'(rdata));
  endtask : t_reg

  // Underflow with fault reset on, overflow with it off, pin reset
  task automatic t_fault;
    wr(7'h01, 4'h0);
    wdt = 1'b1;
    @(negedge clk);
    wdt = 1'b0;
    check("fault enable", 16'h0001, 16'(fen_o));
    run(OP_RET, 14'h0000);
    check("underflow", 16'h0001, 16'(udf));
    check("fault reset", 16'h0001, 16'(frst));
    run(OP_NONE, 14'h0000);
    fen_we = 1'b1;
    @(negedge clk);
    fen_we = 1'b0;
    wr(7'h01, 4'h0);
    run(OP_CALL, 14'h0011);
    check("overflow", 16'h0001, 16'(ovf));
    check("fault reset", 16'h0000, 16'(frst));
    run(OP_NONE, 14'h0000);
    pin = 1'b1;
    @(negedge clk);
    pin = 1'b0;
    check("fault enable", 16'h0001, 16'(fen_o));
  endtask : t_fault

  // Power-on, watchdog and CE resets each preset all ones
  task automatic t_resets;
    for (int k = 0; k < 3; k++) begin
      wr(7'h01, 4'h3);
      por = (k == 0);
      wdt = (k == 1);
      ce = (k == 2);
      @(negedge clk);
      por = 1'b0;
      wdt = 1'b0;
      ce = 1'b0;
      check("index", 16'h000F, 16'(rdata));
    end
  endtask : t_resets

  // Counts, then verdict
  task automatic test_done;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    check("index", 16'h000F, 16'(rdata));
    t_nest();
    t_pairs();
    t_table();
    t_reg();
    t_fault();
    t_resets();
    test_done();
  end

  // Hang guard, well beyond the 82 cycles used
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule : tb_return_address_stack
